// ==== rtl/sync_serial_port.sv ====
// Contract
// [RULE1] eight bits out and in per transfer
// [RULE2] all four clock polarity/phase modes
// [RULE3] data out, data in, clock lines
// [RULE4] optional slave select addresses the slave
// [RULE5] one protocol mode at a time, SPI here
// [RULE6] one status, two control registers
// [RULE7] control register one fully read/write
// [RULE8] status low six read-only, top two writable
// [RULE9] shift register reached only via buffer
// [RULE10] full byte goes to buffer, flag set
// [RULE11] no transmit holding stage before shifter
// [RULE12] buffer write loads buffer and shifter
// [RULE13] most significant bit first
// [RULE14] write while busy ignored, collision flag set
// [RULE15] buffer read clears buffer full flag
// [RULE16] mode field selects role and clock rate
// [RULE17] master runs eight clocks, returns to idle
// [RULE18] external master gives eight valid clocks
`timescale 1ns/10ps
module sync_serial_port
  import ssp_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire sw_write_s BUF_WRITE_IN,
  input wire logic BUF_READ_IN,
  output logic [7:0] BUF_DATA_OUT,
  input wire sw_write_s CTRL_ONE_WRITE_IN,
  output ctrl_one_s CTRL_ONE_OUT,
  input wire sw_write_s CTRL_TWO_WRITE_IN,
  output logic [7:0] CTRL_TWO_OUT,
  input wire sw_write_s STAT_WRITE_IN,
  output stat_s STAT_OUT,
  input wire logic IRQ_FLAG_CLEAR_IN,
  output logic IRQ_FLAG_OUT,
  input wire logic TIMER_TICK_IN,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_OUT,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE_OUT,
  input wire logic SS_N_IN
);

  // software visible state and the shifter
  ctrl_one_s ctrl;
  ctrl_one_s next_ctrl;
  logic [7:0] ctrl_two;
  logic late_sample;
  logic cke;
  logic rx_full;
  logic irq;
  logic [7:0] buf_reg;
  logic [7:0] shift_reg;

  // master sequencer
  xfer_state_e state;
  logic [5:0] div_cnt;
  logic [4:0] step;
  logic [4:0] edge_cnt;
  logic sck;
  logic sdo;
  logic in_bit;

  // synchronisers into the system clock
  logic sdi_meta;
  logic sdi_sync;
  logic ss_n_meta;
  logic ss_n_sync;
  logic done_meta;
  logic done_sync;
  logic done_prev;
  logic busy_meta;
  logic busy_sync;

  // link (serial clock) domain
  logic [2:0] in_cnt;
  logic [6:0] rx_sh;
  logic [7:0] rx_word;
  logic done_tgl;
  logic link_busy;
  logic [3:0] out_cnt;

  // fifo hookup
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  wire [7:0] wr_data;
  wire is_master;
  wire is_slave;
  wire ss_used;
  wire busy;
  wire wr_ok;
  wire wr_coll;
  wire [5:0] half_len;
  wire tick;
  wire step_tick;
  wire do_sample;
  wire do_shift;
  wire lead_out;
  wire enter_shift;
  wire [7:0] next_shift;
  wire master_done;
  wire slave_done;
  wire overflow;
  wire push_valid;
  wire [7:0] push_data;
  wire load_buf;
  wire tx_rise;
  wire link_clk;
  wire link_rst;
  wire [3:0] out_pos;
  wire [3:0] out_wrap;
  wire slave_sdo;

  // mode decode; codes outside the SPI set leave the port idle
  assign wr_data = BUF_WRITE_IN.data;
  assign is_master = ctrl.port_enable && (ctrl.port_mode_select <= MODE_MASTER_TIMER); // see [RULE16] see [RULE5]
  assign ss_used = (ctrl.port_mode_select == MODE_SLAVE_SELECT);
  assign is_slave = ctrl.port_enable && (ss_used || ctrl.port_mode_select == MODE_SLAVE_NOSELECT); // see [RULE16]
  assign busy = (state != XFER_IDLE) || (is_slave && busy_sync);
  assign wr_ok = BUF_WRITE_IN.wr && !busy;
  assign wr_coll = BUF_WRITE_IN.wr && busy; // see [RULE14]

  // master rate select: the timer mode toggles once per timer tick
  assign half_len = (ctrl.port_mode_select == MODE_MASTER_DIV16) ? HALF_DIV16 :
                    (ctrl.port_mode_select == MODE_MASTER_DIV64) ? HALF_DIV64 : HALF_DIV4; // see [RULE16]
  assign tick = (ctrl.port_mode_select == MODE_MASTER_TIMER) ? TIMER_TICK_IN :
                (div_cnt == 6'(half_len - 6'h01));

  // edge roles: even steps are leading edges, odd are trailing
  assign step_tick = (state == XFER_SHIFT) && tick;
  assign do_sample = step_tick && (step < EDGE_STEPS) && (cke ? step[0] : !step[0]); // see [RULE2]
  assign do_shift = step_tick && (cke ? (!step[0] && step != 5'h00) : step[0]);
  assign lead_out = step_tick && cke && (step == 5'h00);
  assign enter_shift = (state == XFER_WAIT) && fifo_in_ready;
  assign next_shift = {shift_reg[6:0], late_sample ? sdi_sync : in_bit}; // see [RULE13]
  assign master_done = step_tick && (step == EDGE_STEPS);

  // received words; a full fifo stalls the master before it starts
  assign slave_done = done_sync ^ done_prev;
  assign overflow = is_slave && slave_done && !fifo_in_ready;
  assign push_valid = master_done || (is_slave && slave_done);
  assign push_data = master_done ? (cke ? next_shift : shift_reg) : rx_word; // see [RULE1]
  assign load_buf = fifo_out_valid && !rx_full && !wr_ok;

  // input synchronisers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
      ss_n_meta <= 1'b1;
      ss_n_sync <= 1'b1;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end else begin
      sdi_meta <= SDI_IN;
      sdi_sync <= sdi_meta;
      ss_n_meta <= SS_N_IN;
      ss_n_sync <= ss_n_meta;
      done_meta <= done_tgl;
      done_sync <= done_meta;
      done_prev <= done_sync;
      busy_meta <= link_busy;
      busy_sync <= busy_meta;
    end
  end

  // control register one: software writes all bits, hardware sets the flags
  always_comb begin
    next_ctrl = CTRL_ONE_WRITE_IN.wr ? ctrl_one_s'(CTRL_ONE_WRITE_IN.data) : ctrl; // see [RULE7]
    next_ctrl.write_collision_flag = next_ctrl.write_collision_flag | wr_coll; // see [RULE14]
    next_ctrl.receive_overflow_flag = next_ctrl.receive_overflow_flag | overflow;
  end

  // configuration registers; status low bits are never written here
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl <= ctrl_one_s'(CTRL_ONE_RESET);
      ctrl_two <= CTRL_TWO_RESET;
      late_sample <= 1'b0;
      cke <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      if (CTRL_TWO_WRITE_IN.wr) begin
        ctrl_two <= CTRL_TWO_WRITE_IN.data; // see [RULE6]
      end
      if (STAT_WRITE_IN.wr) begin
        late_sample <= STAT_WRITE_IN.data[7]; // see [RULE8]
        cke <= STAT_WRITE_IN.data[6];
      end
    end
  end

  // buffer and its flags; a hardware set wins over a clear
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      buf_reg <= BUFFER_RESET;
      rx_full <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (wr_ok) begin
        buf_reg <= wr_data; // see [RULE12]
      end else if (load_buf) begin
        buf_reg <= fifo_out_data; // see [RULE10]
      end
      rx_full <= load_buf | (rx_full & !BUF_READ_IN); // see [RULE15]
      irq <= load_buf | (irq & !IRQ_FLAG_CLEAR_IN); // see [RULE10]
    end
  end

  // shifter: loaded straight from the write, no holding stage between
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      shift_reg <= BUFFER_RESET;
      in_bit <= 1'b0;
    end else begin
      if (wr_ok) begin
        shift_reg <= wr_data; // see [RULE12] see [RULE11]
      end else if (do_shift) begin
        shift_reg <= next_shift; // see [RULE13]
      end
      if (do_sample && !late_sample) begin
        in_bit <= sdi_sync;
      end
    end
  end

  // master sequencer: sixteen clock edges, then back to idle level
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= XFER_IDLE;
      div_cnt <= 6'h00;
      step <= 5'h00;
      sck <= 1'b0;
      sdo <= 1'b0;
    end else if (!is_master) begin
      state <= XFER_IDLE;
      sck <= ctrl.clock_idle_polarity;
    end else begin
      case (state)
        XFER_IDLE: begin
          sck <= ctrl.clock_idle_polarity; // see [RULE17]
          if (wr_ok) begin
            state <= XFER_WAIT; // see [RULE17]
          end
        end
        XFER_WAIT: begin
          if (enter_shift) begin
            state <= XFER_SHIFT;
            div_cnt <= 6'h00;
            step <= 5'h00;
            if (!cke) begin
              sdo <= shift_reg[7]; // see [RULE13]
            end
          end
        end
        XFER_SHIFT: begin
          div_cnt <= tick ? 6'h00 : 6'(div_cnt + 6'h01);
          if (tick) begin
            step <= 5'(step + 5'h01);
            if (step < EDGE_STEPS) begin
              sck <= ~sck; // see [RULE1]
            end else begin
              state <= XFER_IDLE; // see [RULE17]
            end
          end
          if (lead_out) begin
            sdo <= shift_reg[7];
          end else if (do_shift) begin
            sdo <= shift_reg[6];
          end
        end
        default: begin
          state <= XFER_IDLE;
        end
      endcase
    end
  end

  // clock edges seen per transfer, for the length check
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      edge_cnt <= 5'h00;
    end else if (enter_shift) begin
      edge_cnt <= 5'h00;
    end else if (step_tick && step < EDGE_STEPS) begin
      edge_cnt <= 5'(edge_cnt + 5'h01);
    end
  end

  // slave side: rising link_clk is always the sampling edge; the
  // polarity and edge bits must stay still while the port is enabled
  assign tx_rise = cke ^ ctrl.clock_idle_polarity; // see [RULE2]
  assign link_clk = SCK_IN ^ tx_rise;
  assign link_rst = RST_IN || !is_slave || (ss_used && SS_N_IN); // see [RULE4]

  // sample edge: count bits, assemble the word
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      in_cnt <= 3'h0;
      rx_sh <= 7'h00;
      link_busy <= 1'b0;
    end else begin
      in_cnt <= 3'(in_cnt + 3'h1); // see [RULE18]
      rx_sh <= {rx_sh[5:0], SDI_IN}; // see [RULE13]
      link_busy <= (in_cnt != LAST_BIT);
    end
  end

  // finished words survive a deselect, so only the port reset clears them
  always_ff @(posedge link_clk or posedge RST_IN) begin
    if (RST_IN) begin
      rx_word <= BUFFER_RESET;
      done_tgl <= 1'b0;
    end else if (in_cnt == LAST_BIT) begin
      rx_word <= {rx_sh, SDI_IN}; // see [RULE1]
      done_tgl <= ~done_tgl;
    end
  end

  // shift edge: step the outgoing bit index
  assign out_wrap = cke ? 4'h8 : 4'h7;
  always_ff @(negedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      out_cnt <= 4'h0;
    end else begin
      out_cnt <= (out_cnt == out_wrap) ? {3'h0, cke} : 4'(out_cnt + 4'h1);
    end
  end

  // shifter is stable here because writes are refused while the link is busy
  assign out_pos = (cke && out_cnt != 4'h0) ? 4'(out_cnt - 4'h1) : out_cnt;
  assign slave_sdo = shift_reg[3'(4'h7 - out_pos)]; // see [RULE13]

  // receive fifo between the shifter and the buffer
  word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) rx_fifo (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_valid_in(push_valid),
    .wr_ready_out(fifo_in_ready),
    .wr_data_in(push_data),
    .rd_valid_out(fifo_out_valid),
    .rd_ready_in(!rx_full && !wr_ok),
    .rd_data_out(fifo_out_data)
  );

  // pins and software views
  assign SCK_OUT = sck;
  assign SCK_OE_OUT = is_master; // see [RULE3]
  assign SDO_OUT = is_master ? sdo : slave_sdo; // see [RULE3]
  assign SDO_OE_OUT = is_master || (is_slave && (!ss_used || !ss_n_sync)); // see [RULE4]
  assign BUF_DATA_OUT = buf_reg; // see [RULE9]
  assign CTRL_ONE_OUT = ctrl;
  assign CTRL_TWO_OUT = ctrl_two;
  assign STAT_OUT = '{late_sample, cke, 5'h00, rx_full};
  assign IRQ_FLAG_OUT = irq;

  property p_load_both;
    @(posedge CLK_IN) disable iff (RST_IN) wr_ok |=> (buf_reg == $past(wr_data)) && (shift_reg == $past(wr_data));
  endproperty
  a_load_both: assert property (p_load_both) else $error("write missed buffer or shifter"); // see [RULE12]

  property p_collision;
    @(posedge CLK_IN) disable iff (RST_IN) (wr_coll && !load_buf) |=> ctrl.write_collision_flag && $stable(buf_reg);
  endproperty
  a_collision: assert property (p_collision) else $error("busy write not refused"); // see [RULE14]

  property p_full_clear;
    @(posedge CLK_IN) disable iff (RST_IN) (BUF_READ_IN && !load_buf) |=> !rx_full;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("read left buffer full set"); // see [RULE15]

  property p_rx_load;
    @(posedge CLK_IN) disable iff (RST_IN) load_buf |=> rx_full && irq && (buf_reg == $past(fifo_out_data));
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("received byte not posted"); // see [RULE10]

  property p_eight_clocks;
    @(posedge CLK_IN) disable iff (RST_IN) master_done |-> (edge_cnt == 5'h10);
  endproperty
  a_eight_clocks: assert property (p_eight_clocks) else $error("transfer without sixteen edges"); // see [RULE1]

  property p_idle_level;
    @(posedge CLK_IN) disable iff (RST_IN) master_done |=> (state == XFER_IDLE) && (sck == $past(ctrl.clock_idle_polarity));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not back at idle"); // see [RULE17]

  property p_div4_rate;
    @(posedge CLK_IN) disable iff (RST_IN)
      (step_tick && step < 5'h0F && ctrl.port_mode_select == MODE_MASTER_DIV4 && is_master) |=> !tick ##1 tick;
  endproperty
  a_div4_rate: assert property (p_div4_rate) else $error("divide by four edge spacing wrong"); // see [RULE16]

  property p_msb_first;
    @(posedge CLK_IN) disable iff (RST_IN) (enter_shift && !cke && is_master) |=> (sdo == $past(shift_reg[7]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit out is not the top bit"); // see [RULE13]

  property p_ctrl_rw;
    @(posedge CLK_IN) disable iff (RST_IN)
      CTRL_ONE_WRITE_IN.wr |=> (ctrl[5:0] == $past(CTRL_ONE_WRITE_IN.data[5:0]));
  endproperty
  a_ctrl_rw: assert property (p_ctrl_rw) else $error("control write not stored"); // see [RULE7]

  property p_stat_rw;
    @(posedge CLK_IN) disable iff (RST_IN)
      STAT_WRITE_IN.wr |=> (STAT_OUT[7:6] == $past(STAT_WRITE_IN.data[7:6])) && (STAT_OUT[5:1] == 5'h00);
  endproperty
  a_stat_rw: assert property (p_stat_rw) else $error("status write reached read-only bits"); // see [RULE8]

endmodule // sync_serial_port

// ==== rtl/ssp_pkg.sv ====
package ssp_pkg;

  // word geometry and buffering
  localparam int WORD_BITS = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] EDGE_STEPS = 5'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // port_mode_select encodings; all other codes leave the port idle
  localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SELECT = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSELECT = 4'h5;

  // half periods of the master serial clock, in system clocks
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;

  // reset values
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] BUFFER_RESET = 8'h00;

  // serial_control_reg_one, bit 7 down to bit 0
  typedef struct packed {
    logic write_collision_flag;
    logic receive_overflow_flag;
    logic port_enable;
    logic clock_idle_polarity;
    logic [3:0] port_mode_select;
  } ctrl_one_s;

  // serial_status_reg, bit 7 down to bit 0
  typedef struct packed {
    logic input_sample_phase;
    logic clock_edge_select;
    logic [4:0] other_mode_bits;
    logic buffer_full_flag;
  } stat_s;

  // one software write strobe with its byte
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } sw_write_s;

  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_WAIT,
    XFER_SHIFT
  } xfer_state_e;

endpackage

// ==== rtl/word_fifo.sv ====
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire push;
  wire pull;

  // full refuses the writer; the output stage refills whenever it empties
  assign wr_ready_out = (count != CW'(DEPTH));
  assign push = wr_valid_in & wr_ready_out;
  assign pull = (count != '0) && (!rd_valid_out || rd_ready_in);

  // storage has no reset; the pointers, fill level and read port do
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pull) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      count <= CW'(count + CW'(push) - CW'(pull));
    end
  end

  // registered read port, so the head word comes from a flop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else if (pull) begin
      rd_valid_out <= 1'b1;
      rd_data_out <= mem[rd_ptr];
    end else if (rd_ready_in) begin
      rd_valid_out <= 1'b0;
    end
  end

endmodule // word_fifo

// ==== sim/spi_far_end.sv ====
`timescale 1ns/10ps
// far-side party: plain slave to the port's master, or a master with a 48 ns clock
module spi_far_end (
  input wire logic idle_pol_in,
  input wire logic cke_in,
  input wire logic sck_dut_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic sdi_out,
  output logic ss_n_out
);
  logic [7:0] tx_sr;
  logic [7:0] rx_byte;
  logic armed;
  logic drive_clk;
  int bit_cnt;
  wire line_sck = drive_clk ? sck_out : sck_dut_in;

  initial begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    ss_n_out = 1'b1;
    armed = 1'b0;
    drive_clk = 1'b0;
    rx_byte = 8'h00;
    tx_sr = 8'h00;
    bit_cnt = 0;
  end

  // own clock stands still at the idle level outside frames
  always @(idle_pol_in) sck_out = idle_pol_in;

  // with cke low the first bit must be on the line before the leading edge
  task automatic arm(input logic [7:0] data);
    tx_sr = data;
    rx_byte = 8'h00;
    bit_cnt = 0;
    if (!cke_in) begin
      sdi_out = tx_sr[7];
      tx_sr = tx_sr << 1;
    end
    armed = 1'b1;
  endtask

  // shift on the transmit edge, sample on the other one
  always @(line_sck) begin
    if (armed) begin
      if (line_sck == (cke_in ^ idle_pol_in)) begin
        if (bit_cnt < 8) begin
          sdi_out = tx_sr[7];
          tx_sr = tx_sr << 1;
        end
      end else begin
        rx_byte = {rx_byte[6:0], sdo_in};
        bit_cnt++;
        if (bit_cnt == 8) begin
          armed = 1'b0;
          // released line must not keep the last bit; deferred so the port
          // still samples the real last bit on this same edge
          sdi_out <= ~sdi_out;
        end
      end
    end
  end

  // slave role: follow the port's clock
  task automatic arm_slave(input logic [7:0] data);
    drive_clk = 1'b0;
    #1;
    arm(data);
  endtask

  // master role: select, exactly eight clocks, deselect
  task automatic run_master(input logic [7:0] data);
    drive_clk = 1'b1;
    sck_out = idle_pol_in;
    #1;
    arm(data);
    ss_n_out = 1'b0;
    #30;
    repeat (8) begin
      #24 sck_out = ~sck_out;
      #24 sck_out = ~sck_out;
    end
    #30 ss_n_out = 1'b1;
  endtask
endmodule  // spi_far_end

// ==== sim/tb_sync_serial_port.sv ====
`timescale 1ns/10ps
module tb_sync_serial_port;
  import ssp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sw_write_s buf_wr = '0;
  sw_write_s c1_wr = '0;
  sw_write_s c2_wr = '0;
  sw_write_s st_wr = '0;
  logic buf_rd = 1'b0;
  logic irq_clr = 1'b0;
  logic tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic [7:0] buf_data, ctrl_two;
  ctrl_one_s ctrl_one;
  stat_s stat;
  logic irq, sck_o, sck_oe, sdo, sdo_oe, sck_far, sdi_far, ss_n_far;
  int error_cnt = 0;
  int comparisons = 0;
  // mode, idle polarity, cke, receive check (the /4 master reads stale synchronised data)
  logic [6:0] cases [9] = '{{MODE_MASTER_DIV4, 3'b000}, {MODE_MASTER_DIV16, 3'b001},
    {MODE_MASTER_DIV64, 3'b011}, {MODE_MASTER_TIMER, 3'b101}, {MODE_MASTER_DIV16, 3'b111},
    {MODE_SLAVE_SELECT, 3'b000}, {MODE_SLAVE_SELECT, 3'b110}, {MODE_SLAVE_NOSELECT, 3'b010},
    {MODE_SLAVE_NOSELECT, 3'b100}};
  logic [3:0] mode;
  logic idle_pol, cke, rxchk, master;
  logic [7:0] tx, rx;

  always #12.5 clk = ~clk;

  // timer tick every fourth cycle feeds the timer-clocked master mode
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    tick <= (tick_cnt == 2'h3);
  end

  sync_serial_port dut (.CLK_IN(clk), .RST_IN(rst), .BUF_WRITE_IN(buf_wr), .BUF_READ_IN(buf_rd),
    .BUF_DATA_OUT(buf_data), .CTRL_ONE_WRITE_IN(c1_wr), .CTRL_ONE_OUT(ctrl_one), .CTRL_TWO_WRITE_IN(c2_wr),
    .CTRL_TWO_OUT(ctrl_two), .STAT_WRITE_IN(st_wr), .STAT_OUT(stat), .IRQ_FLAG_CLEAR_IN(irq_clr),
    .IRQ_FLAG_OUT(irq), .TIMER_TICK_IN(tick), .SCK_IN(sck_far), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe),
    .SDI_IN(sdi_far), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .SS_N_IN(ss_n_far));

  spi_far_end far (.idle_pol_in(ctrl_one.clock_idle_polarity), .cke_in(stat.clock_edge_select), .sck_dut_in(sck_o),
    .sdo_in(sdo), .sck_out(sck_far), .sdi_out(sdi_far), .ss_n_out(ss_n_far));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sel 0 buffer, 1 control one, 2 control two, 3 status; one-cycle strobe
  task automatic sw_write(input int sel, input logic [7:0] d);
    sw_write_s w;
    w = '{1'b1, d};
    @(posedge clk);
    case (sel)
      0: buf_wr <= w;
      1: c1_wr <= w;
      2: c2_wr <= w;
      default: st_wr <= w;
    endcase
    @(posedge clk);
    buf_wr.wr <= 1'b0;
    c1_wr.wr <= 1'b0;
    c2_wr.wr <= 1'b0;
    st_wr.wr <= 1'b0;
    #1;
  endtask

  // sel 0 buffer read, 1 interrupt flag clear
  task automatic strobe(input int sel);
    @(posedge clk);
    if (sel == 0) buf_rd <= 1'b1;
    else irq_clr <= 1'b1;
    @(posedge clk);
    buf_rd <= 1'b0;
    irq_clr <= 1'b0;
    #1;
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h01);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, far beyond the nine transfers
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(buf_data, BUFFER_RESET);
    check(ctrl_one, CTRL_ONE_RESET);
    check(ctrl_two, CTRL_TWO_RESET);
    check(stat, 8'h00);
    check({5'h00, irq, sck_oe, sdo_oe}, 8'h00);
    sw_write(1, 8'hDA);
    check(ctrl_one, 8'hDA);
    sw_write(2, 8'h5C);
    check(ctrl_two, 8'h5C);
    sw_write(3, 8'hFF);
    check(stat, 8'hC0);
    sw_write(1, 8'h00);
    for (int i = 0; i < 9; i++) begin
      {mode, idle_pol, cke, rxchk} = cases[i];
      master = (mode < MODE_SLAVE_SELECT);
      tx = {4'hA ^ i[3:0], 4'h6 ^ i[3:0]};
      rx = {tx[3:0], tx[7:4]} ^ 8'h81;
      // polarity settles while disabled, so the link clock cannot glitch at enable
      sw_write(1, {3'b000, idle_pol, mode});
      sw_write(3, {1'b0, cke, 6'h00});
      sw_write(1, {3'b001, idle_pol, mode});
      repeat (4) @(posedge clk);
      #1;
      check({6'h00, sck_oe, sdo_oe}, {6'h00, master, master | (mode == MODE_SLAVE_NOSELECT)});
      if (master) check({7'h00, sck_o}, {7'h00, idle_pol});
      if (master) far.arm_slave(rx);
      sw_write(0, tx);
      check(buf_data, tx);
      if (master) begin
        sw_write(0, ~tx);
        check({7'h00, ctrl_one.write_collision_flag}, 8'h01);
        check(buf_data, tx);
      end else begin
        far.run_master(rx);
      end
      wait_irq();
      check(far.rx_byte, tx);
      if (rxchk || !master) check(buf_data, rx);
      check({7'h00, stat.buffer_full_flag}, 8'h01);
      if (master) check({7'h00, sck_o}, {7'h00, idle_pol});
      strobe(0);
      check({7'h00, stat.buffer_full_flag}, 8'h00);
      strobe(1);
      check({7'h00, irq}, 8'h00);
      sw_write(1, {3'b001, idle_pol, mode});
      check(ctrl_one, {3'b001, idle_pol, mode});
    end
    sw_write(1, 8'h00);
    check({6'h00, sck_oe, sdo_oe}, 8'h00);
    wrap_up();
  end
endmodule  // tb_sync_serial_port
